/* File: design/secreg_erase_pkg.sv */
package secreg_erase_pkg;

  // Opcodes
  localparam logic [7:0] OPCODE_ERASE_SECREG = 8'h44;
  localparam logic [7:0] OPCODE_READ_STATUS  = 8'h05;

  // Security register geometry
  localparam int         SECREG_COUNT = 3;
  localparam int         SECREG_BYTES = 256;
  localparam logic [7:0] ERASED_BYTE  = 8'hff;

  // Address field layout and legal values
  localparam int         ADDR_SEL_LSB  = 12;
  localparam int         ADDR_SEL_MSB  = 15;
  localparam int         ADDR_ZERO_LSB = 8;
  localparam int         ADDR_ZERO_MSB = 11;
  localparam int         ADDR_HIGH_LSB = 16;
  localparam logic [3:0] SEL_REG1      = 4'h1;
  localparam logic [3:0] SEL_REG3      = 4'h3;

  // Frame lengths in serial clock edges
  localparam logic [5:0] OPCODE_BITS  = 6'h08;
  localparam logic [5:0] FRAME_BITS_3 = 6'h20;
  localparam logic [5:0] FRAME_BITS_4 = 6'h28;
  localparam logic [5:0] COUNT_MAX    = 6'h3f;

  // Status byte bit positions
  localparam int STATUS_BUSY_BIT         = 0;
  localparam int STATUS_WRITE_ENABLE_BIT = 1;

  // Pin sampler order {csN, sclk, serialDataIn} and idle levels
  localparam logic [2:0] PIN_IDLE = 3'h4;
  localparam int         PIN_CS   = 2;
  localparam int         PIN_SCLK = 1;
  localparam int         PIN_SDI  = 0;

  // Erase timing
  localparam int CLOCK_PERIOD_NS = 5;
  localparam int ERASE_TIME_US   = 50;
  localparam int ERASE_CYCLES    = (ERASE_TIME_US * 1000) / CLOCK_PERIOD_NS;

endpackage

/* File: design/security_register_erase.sv */
// Overview of operation
// - Three 256-byte security registers live apart from the main array and erase singly.
// - The erase opcode is honoured only while the write-enable latch is set.
// - A frame opens with chip select low, then opcode 44h and a 24- or 32-bit address.
// - Address top byte and bits 11..8 must be zero, bits 15..12 of 1..3 pick the register.
// - Chip select must rise right after the last address bit or nothing is executed.
// - A valid frame closed by chip select rising starts a self-timed erase.
// - The read-status opcode is still served while an erase runs.
// - Busy reads 1 for the whole erase and 0 afterwards, when commands are taken again.
// - Completion of the erase clears the write-enable latch unless a set arrives in the same cycle.
// - A register whose one-time lock bit is 1 never accepts an erase.
// - The erase is accepted only in single-line mode, never in four-line mode.
// - In four-byte address mode the frame carries 32 address bits instead of 24.
// - After erase every byte of the register reads FFh and can be programmed again.
module security_register_erase #(
  parameter int ERASE_CYCLES = secreg_erase_pkg::ERASE_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       csN,
  input  wire logic       sclk,
  input  wire logic       serialDataIn,
  input  wire logic       quadMode,
  input  wire logic       fourByteMode,
  input  wire logic [2:0] otp_lock_bits,
  input  wire logic       otherBusy,
  input  wire logic       setWriteEnable,
  input  wire logic       clearWriteEnable,
  input  wire logic       progValid,
  input  wire logic [1:0] progReg,
  input  wire logic [7:0] progAddr,
  input  wire logic [7:0] progData,
  input  wire logic [1:0] readReg,
  input  wire logic [7:0] readAddr,
  output logic            busy,
  output logic            write_enable_latch,
  output logic            serialDataOut,
  output logic            serialDataOutEn,
  output logic [7:0]      readData
);

  logic [2:0]  sync1;
  logic [2:0]  sync2;
  logic [2:0]  sync3;
  logic [2:0]  pinFilt;
  logic [2:0]  pinPrev;
  logic        sclkRise;
  logic        sclkFall;
  logic        csFall;
  logic        csRise;
  logic        csLow;
  logic [5:0]  bitCount;
  logic [39:0] shiftReg;
  logic [7:0]  opcodeReg;
  logic [31:0] frameAddr;
  logic [5:0]  frameBits;
  logic [1:0]  targetSel;
  logic        addrOk;
  logic        cmdOk;
  logic        eraseStart;
  logic        eraseDone;
  logic [1:0]  eraseReg;
  logic [31:0] eraseCount;
  logic        wipeActive;
  logic [7:0]  wipeIdx;
  logic [2:0]  outBit;
  logic [7:0]  statusNow;
  logic [7:0]  mem [0:secreg_erase_pkg::SECREG_COUNT*secreg_erase_pkg::SECREG_BYTES-1];

  // Flat memory index of a register and byte
  function automatic logic [9:0] memIndex(input logic [1:0] sel, input logic [7:0] addr);
    memIndex = {sel, addr};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling: three stages, a change counts when stages two and three agree
  always_ff @(posedge clock) begin
    if (reset) begin
      sync1   <= secreg_erase_pkg::PIN_IDLE;
      sync2   <= secreg_erase_pkg::PIN_IDLE;
      sync3   <= secreg_erase_pkg::PIN_IDLE;
      pinFilt <= secreg_erase_pkg::PIN_IDLE;
      pinPrev <= secreg_erase_pkg::PIN_IDLE;
    end else begin
      sync1   <= {csN, sclk, serialDataIn};
      sync2   <= sync1;
      sync3   <= sync2;
      pinFilt <= (sync2 & ~(sync2 ^ sync3)) | (pinFilt & (sync2 ^ sync3));
      pinPrev <= pinFilt;
    end
  end

  // Edge detection on the filtered pins
  assign csLow    = !pinFilt[secreg_erase_pkg::PIN_CS];
  assign csFall   = pinPrev[secreg_erase_pkg::PIN_CS] && csLow;
  assign csRise   = !pinPrev[secreg_erase_pkg::PIN_CS] && !csLow;
  assign sclkRise = csLow && !pinPrev[secreg_erase_pkg::PIN_SCLK]
                    && pinFilt[secreg_erase_pkg::PIN_SCLK];
  assign sclkFall = csLow && pinPrev[secreg_erase_pkg::PIN_SCLK]
                    && !pinFilt[secreg_erase_pkg::PIN_SCLK];

  ////////////////////////////////////////////////////////////////////////////
  // Frame shifter: opcode then address, counted on rising serial clock
  always_ff @(posedge clock) begin
    if (reset || csFall) begin
      bitCount  <= '0;
      shiftReg  <= '0;
      opcodeReg <= '0;
    end else if (sclkRise) begin
      shiftReg <= {shiftReg[38:0], pinFilt[secreg_erase_pkg::PIN_SDI]};
      if (bitCount != secreg_erase_pkg::COUNT_MAX) begin
        bitCount <= bitCount + 6'h01;
      end
      if (bitCount == secreg_erase_pkg::OPCODE_BITS - 6'h01) begin
        opcodeReg <= {shiftReg[6:0], pinFilt[secreg_erase_pkg::PIN_SDI]};
      end
    end
  end

  // Address width follows addressing mode
  assign frameBits = fourByteMode ? secreg_erase_pkg::FRAME_BITS_4
                                  : secreg_erase_pkg::FRAME_BITS_3;
  assign frameAddr = fourByteMode ? shiftReg[31:0] : {8'h00, shiftReg[23:0]};
  assign targetSel = 2'(frameAddr[secreg_erase_pkg::ADDR_SEL_MSB:secreg_erase_pkg::ADDR_SEL_LSB]
                        - secreg_erase_pkg::SEL_REG1);

  // Legal security register address, low byte ignored
  assign addrOk =
    (frameAddr[31:secreg_erase_pkg::ADDR_HIGH_LSB] == '0)
    && (frameAddr[secreg_erase_pkg::ADDR_ZERO_MSB:secreg_erase_pkg::ADDR_ZERO_LSB] == '0)
    && (frameAddr[secreg_erase_pkg::ADDR_SEL_MSB:secreg_erase_pkg::ADDR_SEL_LSB]
        >= secreg_erase_pkg::SEL_REG1)
    && (frameAddr[secreg_erase_pkg::ADDR_SEL_MSB:secreg_erase_pkg::ADDR_SEL_LSB]
        <= secreg_erase_pkg::SEL_REG3);

  // Every acceptance condition at chip select rise
  assign cmdOk = (opcodeReg == secreg_erase_pkg::OPCODE_ERASE_SECREG)
                 && (bitCount == frameBits)
                 && write_enable_latch
                 && !quadMode
                 && !busy && !otherBusy
                 && addrOk
                 && !otp_lock_bits[targetSel];
  assign eraseStart = csRise && cmdOk;
  assign eraseDone  = busy && !wipeActive && (eraseCount >= 32'(ERASE_CYCLES - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Self-timed erase sequencer and busy flag
  always_ff @(posedge clock) begin
    if (reset) begin
      busy       <= 1'b0;
      eraseReg   <= '0;
      eraseCount <= '0;
      wipeActive <= 1'b0;
      wipeIdx    <= '0;
    end else if (eraseStart) begin
      busy       <= 1'b1;
      eraseReg   <= targetSel;
      eraseCount <= '0;
      wipeActive <= 1'b1;
      wipeIdx    <= '0;
    end else if (busy) begin
      eraseCount <= eraseCount + 32'h1;
      if (wipeActive) begin
        wipeIdx    <= wipeIdx + 8'h01;
        wipeActive <= (wipeIdx != 8'hff);
      end
      if (eraseDone) begin
        busy <= 1'b0;
      end
    end
  end

  // Write-enable latch, a set in the same cycle wins over any clear
  always_ff @(posedge clock) begin
    if (reset) begin
      write_enable_latch <= 1'b0;
    end else if (setWriteEnable) begin
      write_enable_latch <= 1'b1;
    end else if (eraseDone || clearWriteEnable) begin
      write_enable_latch <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Security register storage: wipe to erased value, program clears bits only
  always_ff @(posedge clock) begin
    if (wipeActive) begin
      mem[memIndex(eraseReg, wipeIdx)] <= secreg_erase_pkg::ERASED_BYTE;
    end else if (progValid && !busy && progReg != 2'h3) begin
      mem[memIndex(progReg, progAddr)] <= mem[memIndex(progReg, progAddr)] & progData;
    end
  end

  // Registered read port, out-of-range register reads as erased
  always_ff @(posedge clock) begin
    if (reset) begin
      readData <= secreg_erase_pkg::ERASED_BYTE;
    end else if (readReg == 2'h3) begin
      readData <= secreg_erase_pkg::ERASED_BYTE;
    end else begin
      readData <= mem[memIndex(readReg, readAddr)];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status read path, served even while busy
  always_comb begin
    statusNow = 8'h00;
    statusNow[secreg_erase_pkg::STATUS_BUSY_BIT] = busy;
    statusNow[secreg_erase_pkg::STATUS_WRITE_ENABLE_BIT] = write_enable_latch;
  end

  always_ff @(posedge clock) begin
    if (reset || !csLow) begin
      serialDataOut   <= 1'b0;
      serialDataOutEn <= 1'b0;
      outBit          <= '0;
    end else if (sclkFall && opcodeReg == secreg_erase_pkg::OPCODE_READ_STATUS
                 && bitCount >= secreg_erase_pkg::OPCODE_BITS) begin
      serialDataOutEn <= 1'b1;
      serialDataOut   <= statusNow[~outBit];
      outBit          <= outBit + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  property p_we_needed;
    eraseStart |-> write_enable_latch;
  endproperty
  a_we_needed: assert property (p_we_needed) else $error("erase without write enable");

  property p_opcode;
    eraseStart |-> opcodeReg == 8'h44 && $rose(pinFilt[2]);
  endproperty
  a_opcode: assert property (p_opcode) else $error("erase on wrong opcode");

  property p_addr;
    eraseStart |-> frameAddr[31:16] == 16'h0 && frameAddr[11:8] == 4'h0
                   && frameAddr[15:12] inside {4'h1, 4'h2, 4'h3};
  endproperty
  a_addr: assert property (p_addr) else $error("erase on bad address");

  property p_length;
    eraseStart |-> bitCount == (fourByteMode ? 6'h28 : 6'h20);
  endproperty
  a_length: assert property (p_length) else $error("erase on wrong length");

  property p_busy_hold;
    eraseStart |=> busy [*8];
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");

  property p_busy_end;
    $fell(busy) |-> $past(eraseCount) >= 32'(ERASE_CYCLES - 1) && wipeIdx == 8'h00;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("erase ended early");

  property p_we_clear;
    eraseDone && !setWriteEnable |=> !write_enable_latch;
  endproperty
  a_we_clear: assert property (p_we_clear) else $error("write enable not cleared");

  property p_lock;
    eraseStart |-> !otp_lock_bits[frameAddr[13:12] - 2'h1];
  endproperty
  a_lock: assert property (p_lock) else $error("locked register erased");

  property p_single_line;
    eraseStart |-> !quadMode && !busy && !otherBusy;
  endproperty
  a_single_line: assert property (p_single_line) else $error("erase accepted illegally");

  c_erase: cover property (eraseStart ##[1:300] wipeActive);
  c_status_busy: cover property (busy && serialDataOutEn);
  c_four_byte: cover property (eraseStart && fourByteMode);

endmodule

/* File: test/spi_host_model.sv */
module spi_host_model (
  output logic      csN,
  output logic      sclk,
  output logic      serialDataIn,
  input  wire logic serialDataOut
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle pins, serial clock parked low between frames
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    serialDataIn = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One frame, MSB first; reply bit sampled at each falling edge
  task automatic shift(input logic [39:0] bits, input int n, output logic [7:0] rx);
    rx = 8'h00;
    csN = 1'b0;
    for (int i = 0; i < n; i++) begin
      serialDataIn = bits[39 - i];
      #24 sclk = 1'b1;
      #24 sclk = 1'b0;
      rx = {rx[6:0], serialDataOut};
    end
    #24 csN = 1'b1;
    serialDataIn = ~serialDataIn; // Released line shows no stale bit
    #48;
  endtask
endmodule

/* File: test/security_register_erase_tb.sv */
module security_register_erase_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int ERASE_LEN = 1000;
  logic       clock, reset, csN, sclk, sdi, quadMode, fourByteMode, otherBusy;
  logic       setWriteEnable, clearWriteEnable, progValid, busy, writeLatch, sdo, sdoEn;
  logic [2:0] lockBits;
  logic [1:0] progReg, readReg;
  logic [7:0] progAddr, progData, readAddr, readData, rx;
  int         errors = 0;
  int         n_tests = 0;
  int         cycles = 0;
  int         enCycles = 0;

  security_register_erase #(.ERASE_CYCLES(ERASE_LEN)) i_security_register_erase (
    .clock(clock), .reset(reset), .csN(csN), .sclk(sclk), .serialDataIn(sdi),
    .quadMode(quadMode), .fourByteMode(fourByteMode), .otp_lock_bits(lockBits),
    .otherBusy(otherBusy), .setWriteEnable(setWriteEnable),
    .clearWriteEnable(clearWriteEnable), .progValid(progValid), .progReg(progReg),
    .progAddr(progAddr), .progData(progData), .readReg(readReg), .readAddr(readAddr),
    .busy(busy), .write_enable_latch(writeLatch), .serialDataOut(sdo),
    .serialDataOutEn(sdoEn), .readData(readData));
  spi_host_model i_spi_host_model (
    .csN(csN), .sclk(sclk), .serialDataIn(sdi), .serialDataOut(sdo));

  // Clock and cycle ceiling
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Cycles with the status output enabled
  always @(posedge clock) begin
    if (sdoEn === 1'b1) enCycles++;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic erase(input logic [7:0] op, input logic [31:0] addr, input int n);
    i_spi_host_model.shift(n == 40 ? {op, addr} : {op, addr[23:0], 8'h00}, n, rx);
  endtask
  task automatic refuse(input logic [7:0] op, input logic [31:0] addr, input int n);
    erase(op, addr, n);
    tick(20);
    chk("busy", 1'b0, busy);
  endtask
  task automatic waitIdle();
    for (int i = 0; i < ERASE_LEN + 100 && busy !== 1'b0; i++) tick(1);
  endtask
  task automatic rd(input logic [1:0] r, input logic [7:0] a, input logic [7:0] exp);
    readReg = r;
    readAddr = a;
    tick(2);
    chk8("readData", exp, readData);
  endtask
  task automatic prog(input logic [1:0] r, input logic [7:0] a, input logic [7:0] d);
    progReg = r;
    progAddr = a;
    progData = d;
    progValid = 1'b1;
    tick(1);
    progValid = 1'b0;
    tick(1);
  endtask
  task automatic pulseWe();
    setWriteEnable = 1'b1;
    tick(1);
    setWriteEnable = 1'b0;
    tick(1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_erase_ok();
    int en0;
    pulseWe();
    erase(8'h44, 32'h000010a5, 32);
    tick(8);
    chk("busy", 1'b1, busy);
    en0 = enCycles;
    i_spi_host_model.shift({8'h05, 32'h0}, 16, rx);
    chk8("status", 8'h03, rx);
    chk("sdoEn", 1'b1, enCycles > en0);
    chk("sdoEn", 1'b0, sdoEn);
    waitIdle();
    chk("busy", 1'b0, busy);
    chk("writeLatch", 1'b0, writeLatch);
    i_spi_host_model.shift({8'h05, 32'h0}, 16, rx);
    chk8("status", 8'h00, rx);
    rd(2'h0, 8'hff, 8'hff);
    prog(2'h0, 8'hff, 8'h5a);
    rd(2'h0, 8'hff, 8'h5a);
  endtask
  task automatic t_refusals();
    pulseWe();
    clearWriteEnable = 1'b1;
    tick(1);
    clearWriteEnable = 1'b0;
    refuse(8'h44, 32'h1000, 32);
    pulseWe();
    quadMode = 1'b1;
    refuse(8'h44, 32'h1000, 32);
    quadMode = 1'b0;
    otherBusy = 1'b1;
    refuse(8'h44, 32'h1000, 32);
    otherBusy = 1'b0;
    lockBits = 3'h1;
    refuse(8'h44, 32'h1000, 32);
    rd(2'h0, 8'hff, 8'h5a);
    lockBits = 3'h0;
    refuse(8'h44, 32'h011000, 32);
    refuse(8'h44, 32'h001100, 32);
    refuse(8'h44, 32'h000000, 32);
    refuse(8'h44, 32'h004000, 32);
    refuse(8'h42, 32'h1000, 32);
    refuse(8'h44, 32'h2000, 31);
    refuse(8'h44, 32'h1000, 33);
    chk("writeLatch", 1'b1, writeLatch);
  endtask
  task automatic t_four_byte();
    fourByteMode = 1'b1;
    refuse(8'h44, 32'h3000, 32);
    erase(8'h44, 32'h00003000, 40);
    tick(8);
    chk("busy", 1'b1, busy);
    waitIdle();
    rd(2'h2, 8'h00, 8'hff);
    prog(2'h2, 8'h00, 8'h00);
    fourByteMode = 1'b0;
  endtask
  task automatic t_busy_block();
    pulseWe();
    erase(8'h44, 32'h2000, 32);
    tick(8);
    chk("busy", 1'b1, busy);
    erase(8'h44, 32'h3000, 32);
    waitIdle();
    rd(2'h2, 8'h00, 8'h00);
    rd(2'h1, 8'h40, 8'hff);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and main sequence
  task automatic stop_test();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    {reset, quadMode, fourByteMode, otherBusy, lockBits} = 7'h40;
    {setWriteEnable, clearWriteEnable, progValid, progReg, readReg} = 7'h00;
    {progAddr, progData, readAddr} = 24'h000000;
    tick(2);
    reset = 1'b0;
    tick(4);
    chk("busy", 1'b0, busy);
    chk("writeLatch", 1'b0, writeLatch);
    t_erase_ok();
    t_refusals();
    t_four_byte();
    t_busy_block();
    stop_test();
  end
endmodule
